// File: rtl/airs_top.v
// converter input and reference selection with conversion timing
//
// Overview of operation
// [R1] select register: ref low bits 7:6, align bit 5, channel low 4:0, reset zero
// [R2] three-bit reference code picks supply, pin, 1.1V, reserved or 2.56V with/without bypass
// [R3] reference writes during a conversion apply only once it completes
// [R4] after a reference change the next conversion takes 25 converter ticks
// [R5] software should force a long conversion or discard first results after changes
// [R6] align bit one gives left adjusted data pair, zero right adjusted
// [R7] align bit change alters the data pair view immediately
// [R8] data pair holds the last completed ten-bit result
// [R9] six-bit channel code picks analog inputs and differential gain
// [R10] codes 0 to 10 single-ended inputs, 30 gives 1.1V, 31 gives 0V
// [R11] codes 11 to 29 and 32 to 62 pick differential pairs with gain
// [R12] same-pin codes route one pin to both gain stage inputs
// [R13] code 63 selects the temperature sensor and switches it on
// [R14] channel writes during a conversion apply only once it completes
// [R15] software keeps converter on and waits 1ms after selecting internal reference
// [R16] completion flag sets when a conversion ends and data is updated
// [R17] normal conversion 13 converter ticks, initialising one 25
// [R18] gain alternate bit turns 20x into 32x and 1x into 8x; the code applies it only on channel codes 32 to 63
// [R19] channel top bit sits in control register B
// [R20] effective selection is held for the whole conversion
`include "airs_defines.vh"

module airs_top #(
	parameter NORMAL_TICKS = `AIRS_CONV_NORMAL,
	parameter LONG_TICKS   = `AIRS_CONV_LONG
) (
	// clock and reset
	input  wire       clk_i,
	input  wire       arst_n_i,
	// register port
	input  wire [7:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output wire [7:0] rdata_o,
	// converter side
	input  wire       conv_tick_i,
	input  wire [9:0] sample_i,
	output wire       busy_o,
	output wire       done_o,
	// reference control
	output wire [1:0] ref_src_o,
	output wire       int_ref_on_o,
	output wire       bypass_cap_o,
	// input multiplexer control
	output wire [3:0] mux_pos_o,
	output wire [3:0] mux_neg_o,
	output wire       diff_o,
	output wire [1:0] gain_o,
	output wire       temp_sensor_on_o
);

	// ----------------------------------------
	// software registers
	// ----------------------------------------

	reg  [1:0] ref_sel_low_reg;
	reg        left_align_result_reg;
	reg  [4:0] chan_code_low_reg;
	reg        converter_on_reg;
	reg        conv_done_flag_reg;
	reg        gain_alternate_reg;
	reg        ref_sel_top_reg;
	reg        chan_code_top_reg;

	// conversion state
	reg        busy_reg;
	reg        long_pend_reg;
	reg  [4:0] tick_cnt_reg;
	reg  [4:0] tick_end_reg;
	reg  [9:0] result_reg;
	reg  [2:0] eff_ref_reg;
	reg  [5:0] eff_chan_reg;
	reg        done_reg;

	// output registers
	reg  [7:0] rdata_reg;
	reg  [1:0] ref_src_reg;
	reg        int_ref_on_reg;
	reg        bypass_cap_reg;
	reg  [3:0] mux_pos_reg;
	reg  [3:0] mux_neg_reg;
	reg        diff_reg;
	reg  [1:0] gain_reg;
	reg        temp_on_reg;

	// ----------------------------------------
	// write decode
	// ----------------------------------------

	wire       wr_sel;
	wire       wr_a;
	wire       wr_b;
	wire       start_req;
	wire       done_clr;
	wire       on_next;
	wire       last_tick;
	wire [2:0] ref_code;
	wire [5:0] chan_code;

	assign wr_sel    = wr_i & (addr_i == `AIRS_OFS_IN_REF_SEL);
	assign wr_a      = wr_i & (addr_i == `AIRS_OFS_CTRL_A);
	assign wr_b      = wr_i & (addr_i == `AIRS_OFS_CTRL_B);
	assign on_next   = wr_a ? wdata_i[`AIRS_A_ON] : converter_on_reg;
	// a start is taken only while idle and with the converter on
	assign start_req = wr_a & wdata_i[`AIRS_A_START] & on_next & ~busy_reg;
	assign done_clr  = wr_a & wdata_i[`AIRS_A_DONE];
	assign last_tick = busy_reg & conv_tick_i & (tick_cnt_reg == tick_end_reg);
	// full codes; top bits come from control register B
	assign ref_code  = {ref_sel_top_reg, ref_sel_low_reg};
	assign chan_code = {chan_code_top_reg, chan_code_low_reg}; // R9 R19

	// ----------------------------------------
	// selection register
	// ----------------------------------------

	// fields of the selection register, all read/write
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_sel_low_reg       <= 2'h0; // R1
			left_align_result_reg <= 1'b0;
			chan_code_low_reg     <= 5'h00;
		end else if (wr_sel) begin
			ref_sel_low_reg       <= wdata_i[`AIRS_SEL_REF_HI:`AIRS_SEL_REF_LO]; // R1
			left_align_result_reg <= wdata_i[`AIRS_SEL_LEFT]; // R1
			chan_code_low_reg     <= wdata_i[`AIRS_SEL_CHAN_HI:0]; // R1
		end
	end

	// ----------------------------------------
	// control registers A and B
	// ----------------------------------------

	// enable bit and the selection bits held in register B
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			converter_on_reg   <= 1'b0;
			gain_alternate_reg <= 1'b0;
			ref_sel_top_reg    <= 1'b0;
			chan_code_top_reg  <= 1'b0;
		end else begin
			converter_on_reg <= on_next;
			if (wr_b) begin
				gain_alternate_reg <= wdata_i[`AIRS_B_GAIN_ALT]; // R18
				ref_sel_top_reg    <= wdata_i[`AIRS_B_REF_TOP];
				chan_code_top_reg  <= wdata_i[`AIRS_B_CHAN_TOP]; // R19
			end
		end
	end

	// completion flag: hardware set wins over a write-one clear
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			conv_done_flag_reg <= 1'b0;
		end else if (last_tick) begin
			conv_done_flag_reg <= 1'b1; // R16
		end else if (done_clr) begin
			conv_done_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// effective selection
	// ----------------------------------------

	// follows the registers only while idle, so it is frozen during a conversion
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			eff_ref_reg  <= 3'h0;
			eff_chan_reg <= 6'h00;
		end else if (!busy_reg) begin
			eff_ref_reg  <= ref_code; // R3 R20
			eff_chan_reg <= chan_code; // R14 R20
		end
	end

	// ----------------------------------------
	// conversion timing
	// ----------------------------------------

	// long pending after enabling or after the effective reference changes
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			long_pend_reg <= 1'b0;
		end else if (start_req) begin
			long_pend_reg <= 1'b0;
		end else if (on_next & ~converter_on_reg) begin
			long_pend_reg <= 1'b1; // R17
		end else if (!busy_reg && eff_ref_reg != ref_code) begin
			long_pend_reg <= 1'b1; // R4
		end
	end

	// tick counter; turning the converter off aborts the conversion
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_reg     <= 1'b0;
			tick_cnt_reg <= 5'h00;
			tick_end_reg <= 5'h00;
		end else if (!on_next) begin
			busy_reg     <= 1'b0;
			tick_cnt_reg <= 5'h00;
		end else if (start_req) begin
			busy_reg     <= 1'b1;
			tick_cnt_reg <= 5'h01;
			// an enable in this same cycle or a reference write in the cycle before also forces a long one
			tick_end_reg <= (long_pend_reg | (eff_ref_reg != ref_code) | ~converter_on_reg) ?
				LONG_TICKS[4:0] : NORMAL_TICKS[4:0]; // R4 R17
		end else if (last_tick) begin
			busy_reg     <= 1'b0;
			tick_cnt_reg <= 5'h00;
		end else if (busy_reg && conv_tick_i) begin
			tick_cnt_reg <= tick_cnt_reg + 5'h01;
		end
	end

	// result capture on the final tick
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			result_reg <= 10'h000;
			done_reg   <= 1'b0;
		end else begin
			done_reg <= last_tick;
			if (last_tick) begin
				result_reg <= sample_i; // R8
			end
		end
	end

	// ----------------------------------------
	// decode of the effective selection
	// ----------------------------------------

	wire [3:0] dec_pos;
	wire [3:0] dec_neg;
	wire       dec_diff;
	wire [1:0] dec_gain;

	airs_chan_decode u_chan_decode (
		.code_i     (eff_chan_reg),
		.gain_alt_i (gain_alternate_reg),
		.pos_o      (dec_pos),
		.neg_o      (dec_neg),
		.diff_o     (dec_diff),
		.gain_o     (dec_gain)
	);

	// reference source from the three-bit code
	function [1:0] ref_src_of;
		input [2:0] r;
		begin
			case (r[1:0])
				2'h0: ref_src_of = `AIRS_REF_SUPPLY;
				2'h1: ref_src_of = `AIRS_REF_EXT_PIN;
				2'h2: ref_src_of = r[2] ? `AIRS_REF_INT_2V56 : `AIRS_REF_INT_1V1;
				default: ref_src_of = r[2] ? `AIRS_REF_INT_2V56 : `AIRS_REF_SUPPLY;
			endcase
		end
	endfunction

	// registered mux and reference controls
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_src_reg    <= `AIRS_REF_SUPPLY;
			int_ref_on_reg <= 1'b0;
			bypass_cap_reg <= 1'b0;
			mux_pos_reg    <= 4'h0;
			mux_neg_reg    <= 4'h0;
			diff_reg       <= 1'b0;
			gain_reg       <= `AIRS_GAIN_1X;
			temp_on_reg    <= 1'b0;
		end else begin
			ref_src_reg    <= ref_src_of(eff_ref_reg); // R2
			// reserved code 011 leaves the internal reference off
			int_ref_on_reg <= eff_ref_reg[1] & (eff_ref_reg[2] | ~eff_ref_reg[0]); // R2
			bypass_cap_reg <= (eff_ref_reg == 3'h7); // R2
			mux_pos_reg    <= dec_pos; // R10 R11
			mux_neg_reg    <= dec_neg; // R12
			diff_reg       <= dec_diff; // R11
			gain_reg       <= dec_gain; // R18
			temp_on_reg    <= (eff_chan_reg == 6'h3F); // R13
		end
	end

	// ----------------------------------------
	// read side
	// ----------------------------------------

	wire [7:0] data_lo;
	wire [7:0] data_hi;

	airs_result_format u_result_format (
		.result_i (result_reg),
		.left_i   (left_align_result_reg), // R6 R7
		.lo_o     (data_lo),
		.hi_o     (data_hi)
	);

	// read data one cycle after the strobe, zero otherwise and when unmapped
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= `AIRS_RST_BYTE;
		end else if (rd_i) begin
			case (addr_i)
				`AIRS_OFS_IN_REF_SEL: rdata_reg <= {ref_sel_low_reg, left_align_result_reg, chan_code_low_reg};
				`AIRS_OFS_CTRL_A: rdata_reg <= {converter_on_reg, busy_reg, 1'b0, conv_done_flag_reg, 4'h0};
				`AIRS_OFS_CTRL_B: rdata_reg <= {1'b0, gain_alternate_reg, 1'b0, ref_sel_top_reg,
					chan_code_top_reg, 3'h0};
				`AIRS_OFS_DATA_LO: rdata_reg <= data_lo; // R6
				`AIRS_OFS_DATA_HI: rdata_reg <= data_hi; // R6
				default: rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------

	assign rdata_o          = rdata_reg;
	assign busy_o           = busy_reg;
	assign done_o           = done_reg;
	assign ref_src_o        = ref_src_reg;
	assign int_ref_on_o     = int_ref_on_reg;
	assign bypass_cap_o     = bypass_cap_reg;
	assign mux_pos_o        = mux_pos_reg;
	assign mux_neg_o        = mux_neg_reg;
	assign diff_o           = diff_reg;
	assign gain_o           = gain_reg;
	assign temp_sensor_on_o = temp_on_reg;

endmodule

// File: rtl/airs_defines.vh
// constants for the converter input and reference selection block
`ifndef AIRS_DEFINES_VH
`define AIRS_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define AIRS_OFS_CTRL_B     8'h03
`define AIRS_OFS_DATA_LO    8'h04
`define AIRS_OFS_DATA_HI    8'h05
`define AIRS_OFS_CTRL_A     8'h06
`define AIRS_OFS_IN_REF_SEL 8'h07

// ----------------------------------------
// field positions
// ----------------------------------------
`define AIRS_SEL_REF_HI     7
`define AIRS_SEL_REF_LO     6
`define AIRS_SEL_LEFT       5
`define AIRS_SEL_CHAN_HI    4
`define AIRS_A_ON           7
`define AIRS_A_START        6
`define AIRS_A_DONE         4
`define AIRS_B_GAIN_ALT     6
`define AIRS_B_REF_TOP      4
`define AIRS_B_CHAN_TOP     3

// ----------------------------------------
// reset values
// ----------------------------------------
`define AIRS_RST_BYTE       8'h00

// ----------------------------------------
// reference source codes on ref_src_o
// ----------------------------------------
`define AIRS_REF_SUPPLY     2'h0
`define AIRS_REF_EXT_PIN    2'h1
`define AIRS_REF_INT_1V1    2'h2
`define AIRS_REF_INT_2V56   2'h3

// ----------------------------------------
// gain codes on gain_o
// ----------------------------------------
`define AIRS_GAIN_1X        2'h0
`define AIRS_GAIN_8X        2'h1
`define AIRS_GAIN_20X       2'h2
`define AIRS_GAIN_32X       2'h3

// ----------------------------------------
// conversion lengths in converter clock ticks
// ----------------------------------------
`define AIRS_CONV_NORMAL    13
`define AIRS_CONV_LONG      25

`endif

// File: rtl/airs_chan_decode.v
// decode of the six-bit channel and gain code into mux settings
`include "airs_defines.vh"

module airs_chan_decode (
	// code in
	input  wire [5:0] code_i,
	input  wire       gain_alt_i,
	// mux settings out
	output wire [3:0] pos_o,
	output wire [3:0] neg_o,
	output wire       diff_o,
	output wire [1:0] gain_o
);

	// ----------------------------------------
	// lookup
	// ----------------------------------------

	// {diff, pos, neg, high gain}; single-ended pos 11 temp, 12 1.1V, 13 0V
	function [9:0] lut;
		input [5:0] c;
		begin
			case (c)
				6'h0B: lut = {1'b1, 4'h0, 4'h1, 1'b1};
				6'h0C: lut = {1'b1, 4'h0, 4'h1, 1'b0};
				6'h0D: lut = {1'b1, 4'h1, 4'h1, 1'b1};
				6'h0E: lut = {1'b1, 4'h2, 4'h1, 1'b1};
				6'h0F: lut = {1'b1, 4'h2, 4'h1, 1'b0};
				6'h10: lut = {1'b1, 4'h2, 4'h3, 1'b0};
				6'h11: lut = {1'b1, 4'h3, 4'h3, 1'b1};
				6'h12: lut = {1'b1, 4'h4, 4'h3, 1'b1};
				6'h13: lut = {1'b1, 4'h4, 4'h3, 1'b0};
				6'h14: lut = {1'b1, 4'h4, 4'h5, 1'b1};
				6'h15: lut = {1'b1, 4'h4, 4'h5, 1'b0};
				6'h16: lut = {1'b1, 4'h5, 4'h5, 1'b1};
				6'h17: lut = {1'b1, 4'h6, 4'h5, 1'b1};
				6'h18: lut = {1'b1, 4'h6, 4'h5, 1'b0};
				6'h19: lut = {1'b1, 4'h8, 4'h9, 1'b1};
				6'h1A: lut = {1'b1, 4'h8, 4'h9, 1'b0};
				6'h1B: lut = {1'b1, 4'h9, 4'h9, 1'b1};
				6'h1C: lut = {1'b1, 4'hA, 4'h9, 1'b1};
				6'h1D: lut = {1'b1, 4'hA, 4'h9, 1'b0};
				6'h1E: lut = {1'b0, 4'hC, 4'h0, 1'b0};
				6'h1F: lut = {1'b0, 4'hD, 4'h0, 1'b0};
				6'h20: lut = {1'b1, 4'h0, 4'h1, 1'b1};
				6'h21: lut = {1'b1, 4'h0, 4'h1, 1'b0};
				6'h22: lut = {1'b1, 4'h1, 4'h0, 1'b1};
				6'h23: lut = {1'b1, 4'h1, 4'h0, 1'b0};
				6'h24: lut = {1'b1, 4'h1, 4'h2, 1'b1};
				6'h25: lut = {1'b1, 4'h1, 4'h2, 1'b0};
				6'h26: lut = {1'b1, 4'h2, 4'h1, 1'b1};
				6'h27: lut = {1'b1, 4'h2, 4'h1, 1'b0};
				6'h28: lut = {1'b1, 4'h2, 4'h0, 1'b1};
				6'h29: lut = {1'b1, 4'h2, 4'h0, 1'b0};
				6'h2A: lut = {1'b1, 4'h0, 4'h2, 1'b1};
				6'h2B: lut = {1'b1, 4'h0, 4'h2, 1'b0};
				6'h2C: lut = {1'b1, 4'h4, 4'h5, 1'b1};
				6'h2D: lut = {1'b1, 4'h4, 4'h5, 1'b0};
				6'h2E: lut = {1'b1, 4'h5, 4'h4, 1'b1};
				6'h2F: lut = {1'b1, 4'h5, 4'h4, 1'b0};
				6'h30: lut = {1'b1, 4'h5, 4'h6, 1'b1};
				6'h31: lut = {1'b1, 4'h5, 4'h6, 1'b0};
				6'h32: lut = {1'b1, 4'h6, 4'h5, 1'b1};
				6'h33: lut = {1'b1, 4'h6, 4'h5, 1'b0};
				6'h34: lut = {1'b1, 4'h6, 4'h4, 1'b1};
				6'h35: lut = {1'b1, 4'h6, 4'h4, 1'b0};
				6'h36: lut = {1'b1, 4'h4, 4'h6, 1'b1};
				6'h37: lut = {1'b1, 4'h4, 4'h6, 1'b0};
				6'h38: lut = {1'b1, 4'h0, 4'h0, 1'b1};
				6'h39: lut = {1'b1, 4'h0, 4'h0, 1'b0};
				6'h3A: lut = {1'b1, 4'h1, 4'h1, 1'b1};
				6'h3B: lut = {1'b1, 4'h2, 4'h2, 1'b1};
				6'h3C: lut = {1'b1, 4'h4, 4'h4, 1'b1};
				6'h3D: lut = {1'b1, 4'h5, 4'h5, 1'b1};
				6'h3E: lut = {1'b1, 4'h6, 4'h6, 1'b1};
				6'h3F: lut = {1'b0, 4'hB, 4'h0, 1'b0};
				default: lut = {1'b0, c[3:0], 4'h0, 1'b0};
			endcase
		end
	endfunction

	// ----------------------------------------
	// outputs
	// ----------------------------------------

	wire [9:0] ent;
	wire       alt;

	assign ent    = lut(code_i);
	// alternate gains only exist on channel codes 32 to 63
	assign alt    = gain_alt_i & code_i[5];
	assign diff_o = ent[9];
	assign pos_o  = ent[8:5];
	assign neg_o  = ent[4:1];
	assign gain_o = ent[0] ? (alt ? `AIRS_GAIN_32X : `AIRS_GAIN_20X) : (alt ? `AIRS_GAIN_8X : `AIRS_GAIN_1X);

endmodule

// File: rtl/airs_result_format.v
// presentation of the ten-bit result in the data register pair
module airs_result_format (
	// result in
	input  wire [9:0] result_i,
	input  wire       left_i,
	// data pair out
	output wire [7:0] lo_o,
	output wire [7:0] hi_o
);

	// ----------------------------------------
	// alignment
	// ----------------------------------------

	// purely combinational so an alignment change shows at once
	assign lo_o = left_i ? {result_i[1:0], 6'h00} : result_i[7:0];
	assign hi_o = left_i ? result_i[9:2] : {6'h00, result_i[9:8]};

endmodule

// File: verification/airs_properties.sv
// port assertions for the input and reference selection block
module airs_properties #(
	parameter NORMAL_TICKS = 13,
	parameter LONG_TICKS   = 25
) (
	// clock and reset
	input wire       clk_i,
	input wire       arst_n_i,
	// register port
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o,
	// converter side
	input wire       conv_tick_i,
	input wire [9:0] sample_i,
	input wire       busy_o,
	input wire       done_o,
	// reference and mux control
	input wire [1:0] ref_src_o,
	input wire       int_ref_on_o,
	input wire       bypass_cap_o,
	input wire [3:0] mux_pos_o,
	input wire [3:0] mux_neg_o,
	input wire       diff_o,
	input wire [1:0] gain_o,
	input wire       temp_sensor_on_o
);
	// --------------------
	// helper logic
	// --------------------
	reg  [5:0] tick_cnt_reg;
	wire       abort_w;

	// a write that switches the converter off ends a conversion without result
	assign abort_w = wr_i && (addr_i == 8'h06) && !wdata_i[7];

	// ticks seen while busy, cleared when idle
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			tick_cnt_reg <= 6'h00;
		else if (!busy_o)
			tick_cnt_reg <= 6'h00;
		else if (conv_tick_i)
			tick_cnt_reg <= tick_cnt_reg + 6'h01;
	end

	// --------------------
	// assertions
	// --------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_conv_length: assert property (
		$fell(busy_o) && !$past(abort_w) |-> $past(conv_tick_i)
		&& ($past(tick_cnt_reg) == NORMAL_TICKS - 1 || $past(tick_cnt_reg) == LONG_TICKS - 1))
		else $error("conversion ended on a wrong tick");
	a_start_busy: assert property (
		wr_i && addr_i == 8'h06 && wdata_i[7] && wdata_i[6] && !busy_o |=> busy_o)
		else $error("start write did not raise busy");
	a_done_follows: assert property ($fell(busy_o) && !$past(abort_w) |-> done_o)
		else $error("no done pulse after conversion end");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done pulse longer than one cycle");
	a_done_cause: assert property (done_o |-> $past(busy_o) && $past(conv_tick_i) && !busy_o)
		else $error("done pulse without a finished conversion");
	a_sel_frozen: assert property (
		busy_o && $past(busy_o) && $past(busy_o, 2) && $past(busy_o, 3)
		|-> $stable(mux_pos_o) && $stable(mux_neg_o) && $stable(diff_o) && $stable(ref_src_o))
		else $error("selection changed during a conversion");
	a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside the read cycle");
	a_temp_sel: assert property (temp_sensor_on_o |-> mux_pos_o == 4'hB && !diff_o)
		else $error("sensor on without sensor channel");
	a_bypass_ref: assert property (bypass_cap_o |-> ref_src_o == 2'h3 && int_ref_on_o)
		else $error("bypass without internal 2.56V reference");
	a_int_ref: assert property (int_ref_on_o == ref_src_o[1])
		else $error("internal reference enable disagrees with source");
	a_single_neg: assert property (!diff_o |-> mux_neg_o == 4'h0)
		else $error("negative input set on single-ended channel");
endmodule

bind airs_top airs_properties #(
	.NORMAL_TICKS(NORMAL_TICKS),
	.LONG_TICKS  (LONG_TICKS)
) u_props (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .conv_tick_i(conv_tick_i), .sample_i(sample_i), .busy_o(busy_o), .done_o(done_o),
	.ref_src_o(ref_src_o), .int_ref_on_o(int_ref_on_o), .bypass_cap_o(bypass_cap_o),
	.mux_pos_o(mux_pos_o), .mux_neg_o(mux_neg_o), .diff_o(diff_o), .gain_o(gain_o),
	.temp_sensor_on_o(temp_sensor_on_o)
);

// File: verification/tb_adc_input_reference_select.sv
// self-checking bench for the input and reference selection block
module tb_adc_input_reference_select;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N_NORM = 13;
	localparam int N_LONG = 25;
	logic       clk_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       conv_tick_i = 1'b0;
	logic [9:0] sample_i = 10'h000;
	wire  [7:0] rdata_o;
	wire        busy_o;
	wire        done_o;
	wire  [1:0] ref_src_o;
	wire        int_ref_on_o;
	wire        bypass_cap_o;
	wire  [3:0] mux_pos_o;
	wire  [3:0] mux_neg_o;
	wire        diff_o;
	wire  [1:0] gain_o;
	wire        temp_sensor_on_o;
	int         n_fail = 0;
	int         cmp_count = 0;
	int         cycles = 0;
	logic [7:0] rv;

	airs_top #(.NORMAL_TICKS(N_NORM), .LONG_TICKS(N_LONG)) u_dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .conv_tick_i(conv_tick_i), .sample_i(sample_i), .busy_o(busy_o), .done_o(done_o),
		.ref_src_o(ref_src_o), .int_ref_on_o(int_ref_on_o), .bypass_cap_o(bypass_cap_o),
		.mux_pos_o(mux_pos_o), .mux_neg_o(mux_neg_o), .diff_o(diff_o), .gain_o(gain_o),
		.temp_sensor_on_o(temp_sensor_on_o)
	);

	// --------------------
	// bus and compare helpers
	// --------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		#1;
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		#1;
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	task automatic settle;
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	task automatic start(input logic [7:0] ctrl);
		wr(8'h06, ctrl);
		@(posedge clk_i);
		#1;
		chk({7'h00, busy_o}, 8'h01);
	endtask

	// one tick every second cycle until busy drops, then look for the done pulse
	task automatic finish(input logic [9:0] s, input int exp_n);
		int n;
		n = 0;
		sample_i <= s;
		while (busy_o === 1'b1 && n < 40) begin
			@(posedge clk_i);
			conv_tick_i <= 1'b1;
			@(posedge clk_i);
			conv_tick_i <= 1'b0;
			n++;
			#1;
		end
		chk(8'(n), 8'(exp_n));
		chk({7'h00, done_o}, 8'h01);
	endtask

	// --------------------
	// scenarios
	// --------------------
	task automatic t_regs;
		rc(8'h07, 8'h00);
		rc(8'h03, 8'h00);
		rc(8'h05, 8'h00);
		rc(8'h10, 8'h00);
		wr(8'h07, 8'hA5);
		rc(8'h07, 8'hA5);
		wr(8'h07, 8'h5A);
		rc(8'h07, 8'h5A);
		wr(8'h03, 8'hFF);
		rc(8'h03, 8'h58);
		wr(8'h04, 8'hFF);
		rc(8'h04, 8'h00);
		$display("test registers done");
	endtask

	// entry: alt, code, pos, neg, diff, gain, sensor
	task automatic t_chan;
		logic [18:0] tbl [15];
		logic [18:0] e;
		tbl = '{19'h00000, 19'h0AA00, 19'h1EC00, 19'h1FD00, 19'h0B01C, 19'h0C018, 19'h0D11C, 19'h3800C,
			19'h6101A, 19'h6001E, 19'h3265C, 19'h3FB01, 19'h1DA98, 19'h03300, 19'h4B01C};
		foreach (tbl[i]) begin
			e = tbl[i];
			wr(8'h03, {1'b0, e[18], 2'b00, e[17], 3'b000});
			wr(8'h07, {3'b000, e[16:12]});
			settle();
			chk({mux_pos_o, mux_neg_o}, e[11:4]);
			chk({4'h0, diff_o, gain_o, temp_sensor_on_o}, {4'h0, e[3:0]});
		end
		$display("test channels done");
	endtask

	task automatic t_ref;
		logic [31:0] exp_tbl;
		exp_tbl = 32'hFE40_0A40;
		for (int i = 0; i < 8; i++) begin
			wr(8'h03, {3'b000, i[2], 4'h0});
			wr(8'h07, {i[1:0], 6'h00});
			settle();
			chk({4'h0, ref_src_o, int_ref_on_o, bypass_cap_o}, {4'h0, exp_tbl[4*i +: 4]});
		end
		$display("test references done");
	endtask

	task automatic t_conv;
		wr(8'h03, 8'h00);
		wr(8'h07, 8'h00);
		start(8'hC0);
		finish(10'h2B5, N_LONG);
		rc(8'h06, 8'h90);
		rc(8'h04, 8'hB5);
		rc(8'h05, 8'h02);
		wr(8'h07, 8'h20);
		rc(8'h04, 8'h40);
		rc(8'h05, 8'hAD);
		wr(8'h06, 8'h90);
		rc(8'h06, 8'h80);
		start(8'hC0);
		finish(10'h3C1, N_NORM);
		rc(8'h05, 8'hF0);
		rc(8'h04, 8'h40);
		$display("test conversions done");
	endtask

	task automatic t_hold;
		wr(8'h07, 8'h03);
		settle();
		start(8'hC0);
		wr(8'h07, 8'h8A);
		settle();
		chk({mux_pos_o, 2'b00, ref_src_o}, 8'h30);
		finish(10'h001, N_NORM);
		settle();
		chk({mux_pos_o, 2'b00, ref_src_o}, 8'hA2);
		repeat (20000) @(posedge clk_i);
		start(8'hC0);
		finish(10'h002, N_LONG);
		wr(8'h06, 8'h90);
		start(8'hC0);
		wr(8'h06, 8'h00);
		#1;
		chk({7'h00, busy_o}, 8'h00);
		rc(8'h06, 8'h00);
		start(8'hC0);
		finish(10'h003, N_LONG);
		$display("test hold and abort done");
	endtask

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// clock
	initial begin
		forever #25 clk_i = ~clk_i;
	end

	// cut a hang short
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			summarize();
		end
	end

	// main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_chan();
		t_ref();
		t_conv();
		t_hold();
		summarize();
	end
endmodule
